// >>> tpio_top.v
// Contract
// - top bits 00: compare, initial low
// - bits 01: compare, initial high
// - toggle inverts pin each match
// - 1000 captures on rising pin edge
// - 1001 captures on falling pin edge
// - 101x captures on both pin edges
// - no cascade source: second bit ignored in capture modes
// - ch3 D 11xx captures on ch4 count
// - ch0 A 11xx captures on ch1 count
// - ch4 B 11xx captures on ch3 C event
// - undivided neighbour clock: no cascade capture
// - buffer mode ch3 D: no events
`timescale 1ns/1ns
`include "tpio_defines.vh"
module tpio_top #(
   parameter W = 16
) (
   input  wire           mclk,
   input  wire           rst,
   input  wire           psel,
   input  wire           penable,
   input  wire           pwrite,
   input  wire [7:0]     paddr,
   input  wire [31:0]    pwdata,
   output wire [31:0]    prdata,
   output wire           pready,
   output wire           pslverr,
   input  wire [4*W-1:0] counter_in,
   input  wire           count_tick_ch4,
   input  wire           count_tick_ch1,
   input  wire           reg_c_event_ch3,
   input  wire [3:0]     pin_in,
   output wire [3:0]     pin_out,
   output wire [3:0]     pin_oe,
   output wire [3:0]     capture_pulse,
   output wire [3:0]     match_pulse
);
   reg  [7:0]     ctrl_ff [0:3];
   reg  [8:0]     config_ff;
   reg  [31:0]    prdata_ff;
   reg            pready_ff;
   reg            pslverr_ff;
   reg  [31:0]    nxt_prdata;
   reg            nxt_slverr;
   wire           acc;
   wire           wr;
   wire [3:0]     mode [0:3];
   wire [3:0]     mode_wr;
   wire [3:0]     gen_wr;
   wire [3:0]     cascade;
   wire [3:0]     suppress;
   wire [4*W-1:0] gen_bus;
   wire [2:0]     psc4;
   wire [2:0]     psc1;
   wire           buffer_b_enable;

   ////////////////////////////////////////////////////////////////////////
   // apb: answer one cycle into the access phase
   assign acc = psel & penable & ~pready_ff;
   assign wr  = acc & pwrite;

   assign psc4            = config_ff[`TPIO_CFG_PSC4_MSB:`TPIO_CFG_PSC4_LSB];
   assign psc1            = config_ff[`TPIO_CFG_PSC1_MSB:`TPIO_CFG_PSC1_LSB];
   assign buffer_b_enable = config_ff[`TPIO_CFG_BUFB_BIT];

   // slot 0 ch3 D, 1 ch4 B, 2 ch5 B in high nibble; slot 3 ch0 A low nibble
   assign mode[0] = ctrl_ff[0][`TPIO_FLD_HI_MSB:`TPIO_FLD_HI_LSB];
   assign mode[1] = ctrl_ff[1][`TPIO_FLD_HI_MSB:`TPIO_FLD_HI_LSB];
   assign mode[2] = ctrl_ff[2][`TPIO_FLD_HI_MSB:`TPIO_FLD_HI_LSB];
   assign mode[3] = ctrl_ff[3][`TPIO_FLD_LO_MSB:`TPIO_FLD_LO_LSB];

   // count ticks on an undivided clock cannot be told apart
   assign cascade[0]  = count_tick_ch4 & (psc4 != `TPIO_PSC_UNDIVIDED);
   assign cascade[1]  = reg_c_event_ch3;
   assign cascade[2]  = 1'b0;
   assign cascade[3]  = count_tick_ch1 & (psc1 != `TPIO_PSC_UNDIVIDED);
   assign suppress[0] = buffer_b_enable;
   assign suppress[3:1] = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : slot
         assign mode_wr[g] = wr & (paddr == (`TPIO_OFF_CTRL_CH3 + 8'h04 * g));
         assign gen_wr[g]  = wr & (paddr == (`TPIO_OFF_GEN_D_CH3 + 8'h04 * g));
         always @(posedge mclk) begin
            if (rst) begin
               ctrl_ff[g] <= `TPIO_RST_CTRL;
            end else if (mode_wr[g]) begin
               ctrl_ff[g] <= pwdata[7:0];
            end
         end
         tpio_chan #(
            .W       (W),
            .CASCADE ((g == 0 || g == 1 || g == 3) ? 1 : 0)
         ) u_chan (
            .mclk          (mclk),
            .rst           (rst),
            .mode          (ctrl_mode_nxt(g)),
            .mode_wr       (mode_wr[g]),
            .counter       (counter_in[g*W +: W]),
            .sw_wr         (gen_wr[g]),
            .sw_data       (pwdata[W-1:0]),
            .pin_in        (pin_in[g]),
            .cascade_evt   (cascade[g]),
            .suppress      (suppress[g]),
            .gen_reg       (gen_bus[g*W +: W]),
            .pin_out       (pin_out[g]),
            .pin_oe        (pin_oe[g]),
            .capture_pulse (capture_pulse[g]),
            .match_pulse   (match_pulse[g])
         );
      end
   endgenerate

   // during a mode write the channel sees the new field at once
   function [3:0] ctrl_mode_nxt;
      input integer s;
      begin
         if (mode_wr[s]) begin
            ctrl_mode_nxt = (s == 3) ? pwdata[`TPIO_FLD_LO_MSB:`TPIO_FLD_LO_LSB]
                                     : pwdata[`TPIO_FLD_HI_MSB:`TPIO_FLD_HI_LSB];
         end else begin
            ctrl_mode_nxt = mode[s];
         end
      end
   endfunction

   always @(posedge mclk) begin
      if (rst) begin
         config_ff <= `TPIO_RST_CONFIG;
      end else if (wr && paddr == `TPIO_OFF_CONFIG) begin
         config_ff <= pwdata[8:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      case (paddr)
         `TPIO_OFF_CTRL_CH3:  nxt_prdata[7:0] = ctrl_ff[0];
         `TPIO_OFF_CTRL_CH4:  nxt_prdata[7:0] = ctrl_ff[1];
         `TPIO_OFF_CTRL_CH5:  nxt_prdata[7:0] = ctrl_ff[2];
         `TPIO_OFF_CTRL_CH0:  nxt_prdata[7:0] = ctrl_ff[3];
         `TPIO_OFF_GEN_D_CH3: nxt_prdata[W-1:0] = gen_bus[0*W +: W];
         `TPIO_OFF_GEN_B_CH4: nxt_prdata[W-1:0] = gen_bus[1*W +: W];
         `TPIO_OFF_GEN_B_CH5: nxt_prdata[W-1:0] = gen_bus[2*W +: W];
         `TPIO_OFF_GEN_A_CH0: nxt_prdata[W-1:0] = gen_bus[3*W +: W];
         `TPIO_OFF_CONFIG:    nxt_prdata[8:0] = config_ff;
         `TPIO_OFF_STATUS:    nxt_prdata[7:0] = {pin_oe, pin_out};
         default:             nxt_slverr = 1'b1;
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         prdata_ff  <= 32'h00000000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= acc;
         pslverr_ff <= acc & nxt_slverr;
         if (acc && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
endmodule

// >>> tpio_defines.vh
`ifndef TPIO_DEFINES_VH
`define TPIO_DEFINES_VH
// register byte offsets
`define TPIO_OFF_CTRL_CH3    8'h00
`define TPIO_OFF_CTRL_CH4    8'h04
`define TPIO_OFF_CTRL_CH5    8'h08
`define TPIO_OFF_CTRL_CH0    8'h0C
`define TPIO_OFF_GEN_D_CH3   8'h10
`define TPIO_OFF_GEN_B_CH4   8'h14
`define TPIO_OFF_GEN_B_CH5   8'h18
`define TPIO_OFF_GEN_A_CH0   8'h1C
`define TPIO_OFF_CONFIG      8'h20
`define TPIO_OFF_STATUS      8'h24
// field positions
`define TPIO_FLD_HI_MSB      7
`define TPIO_FLD_HI_LSB      4
`define TPIO_FLD_LO_MSB      3
`define TPIO_FLD_LO_LSB      0
`define TPIO_CFG_PSC4_MSB    2
`define TPIO_CFG_PSC4_LSB    0
`define TPIO_CFG_PSC1_MSB    5
`define TPIO_CFG_PSC1_LSB    3
`define TPIO_CFG_BUFB_BIT    8
// reset values
`define TPIO_RST_CTRL        8'h00
`define TPIO_RST_GEN         16'h0000
`define TPIO_RST_CONFIG      9'h000
// prescaler code for the undivided clock
`define TPIO_PSC_UNDIVIDED   3'h0
`endif

// >>> tpio_chan.v
`timescale 1ns/1ns
`include "tpio_defines.vh"
module tpio_chan #(
   parameter W       = 16,
   parameter CASCADE = 1
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire [3:0]   mode,
   input  wire         mode_wr,
   input  wire [W-1:0] counter,
   input  wire         sw_wr,
   input  wire [W-1:0] sw_data,
   input  wire         pin_in,
   input  wire         cascade_evt,
   input  wire         suppress,
   output wire [W-1:0] gen_reg,
   output wire         pin_out,
   output wire         pin_oe,
   output wire         capture_pulse,
   output wire         match_pulse
);
   reg [W-1:0] gen_ff;
   reg         sync1_ff;
   reg         sync2_ff;
   reg         sync3_ff;
   reg         eq_ff;
   reg         out_ff;
   reg         oe_ff;
   reg         cap_ff;
   reg         mat_ff;
   wire        rise;
   wire        fall;
   wire        pin_edge;
   wire        is_cap;
   wire        cas_sel;
   wire        cap_evt;
   wire        eq;
   wire        match;
   reg         nxt_out;
   reg         nxt_oe;

   ////////////////////////////////////////////////////////////////////////
   // first stage read only by second stage
   always @(posedge mclk) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   assign rise     = sync2_ff & ~sync3_ff;
   assign fall     = ~sync2_ff & sync3_ff;
   assign is_cap   = mode[3];
   // channels without a cascade source ignore the second field bit in capture modes
   assign cas_sel  = (CASCADE != 0) & mode[2];
   assign pin_edge = mode[1] ? (rise | fall) :
                     (mode[0] ? fall : rise);
   assign cap_evt  = ~suppress & is_cap & (cas_sel ? cascade_evt : pin_edge);

   // one match per equality run, so a slow counter toggles once
   assign eq    = (counter == gen_ff);
   assign match = ~suppress & ~is_cap & (mode[1:0] != 2'b00) & eq & ~eq_ff;

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      nxt_out = out_ff;
      nxt_oe  = oe_ff;
      if (mode_wr) begin
         nxt_oe  = ~mode[3] & (mode[1:0] != 2'b00);
         nxt_out = mode[3] ? out_ff : mode[2];
      end else if (match) begin
         case (mode[1:0])
            2'b01:   nxt_out = 1'b0;
            2'b10:   nxt_out = 1'b1;
            2'b11:   nxt_out = ~out_ff;
            default: nxt_out = out_ff;
         endcase
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         gen_ff <= `TPIO_RST_GEN;
         eq_ff  <= 1'b0;
         out_ff <= 1'b0;
         oe_ff  <= 1'b0;
         cap_ff <= 1'b0;
         mat_ff <= 1'b0;
      end else begin
         eq_ff  <= eq;
         out_ff <= nxt_out;
         oe_ff  <= nxt_oe;
         cap_ff <= cap_evt;
         mat_ff <= match;
         // a capture beats a software write in the same cycle
         if (cap_evt) begin
            gen_ff <= counter;
         end else if (sw_wr) begin
            gen_ff <= sw_data;
         end
      end
   end

   assign gen_reg       = gen_ff;
   assign pin_out       = out_ff;
   assign pin_oe        = oe_ff;
   assign capture_pulse = cap_ff;
   assign match_pulse   = mat_ff;
endmodule

// >>> tpio_properties.sv
`timescale 1ns/1ns
module tpio_props (
   input wire       mclk,
   input wire       rst,
   input wire       psel,
   input wire       penable,
   input wire       pwrite,
   input wire       pready,
   input wire       pslverr,
   input wire [3:0] pin_in,
   input wire [3:0] pin_out,
   input wire [3:0] pin_oe,
   input wire [3:0] capture_pulse,
   input wire [3:0] match_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   a_ready_next:
      assert property (psel && penable && !pready |=> pready) else $error("no answer");
   a_ready_single:
      assert property (pready |=> !pready) else $error("ready held too long");
   a_err_with_ready:
      assert property (pslverr |-> pready) else $error("error without ready");
   a_oe_by_write:
      assert property ($changed(pin_oe) |-> $past(psel && penable && pwrite))
      else $error("enable moved without write");
   a_out_by_event:
      assert property ($changed(pin_out) |-> match_pulse != 4'h0 || $past(psel && pwrite))
      else $error("pin moved without cause");
   a_match_once:
      assert property ((match_pulse & $past(match_pulse)) == 4'h0) else $error("match repeated");
   a_mode_exclusive:
      assert property ((capture_pulse & match_pulse) == 4'h0) else $error("both events");
   a_sync_delay:
      assert property (capture_pulse[2] |-> $past(pin_in[2], 3) != $past(pin_in[2], 4))
      else $error("capture without pin edge");
   c_capture: cover property (capture_pulse != 4'h0);
   c_match: cover property (match_pulse != 4'h0);
   c_refused: cover property (pslverr);
endmodule
bind tpio_top tpio_props u_props (.mclk, .rst, .psel, .penable, .pwrite, .pready, .pslverr,
   .pin_in, .pin_out, .pin_oe, .capture_pulse, .match_pulse);

// >>> tpio_pins.sv
`timescale 1ns/1ns
// external pin drivers; the device wins wherever it drives
module tpio_pins (
   input  wire [3:0] drv_lvl,
   input  wire [3:0] pin_out,
   input  wire [3:0] pin_oe,
   output wire [3:0] pin_level
);
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule

// >>> tpio_top_bench.sv
`timescale 1ns/1ns
module tpio_top_bench;
   logic        mclk, rst, psel, penable, pwrite, lvl, en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, d;
   logic [63:0] cnt;
   logic [2:0]  tick;
   logic [3:0]  drv;
   logic [8:0]  cfg;
   logic [15:0] v, g, prev, d3, b4, a0;
   logic [64:0] expq[$];
   logic [3:0]  capq[$], matq[$];
   wire  [3:0]  cap, mat;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   wire  [3:0]  pin_out, pin_oe, pin_lvl;
   int          err_count, n_checks, i, j, k;
   tpio_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_in(cnt), .count_tick_ch4(tick[0]), .count_tick_ch1(tick[1]),
      .reg_c_event_ch3(tick[2]), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
      .capture_pulse(cap), .match_pulse(mat));
   tpio_pins u_pins (.drv_lvl(drv), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_lvl));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   ////////////////////////////////////////
   // note layout: mask, error, data
   task automatic chk(input logic [64:0] e, input logic [31:0] got, input logic ge);
      n_checks++;
      if ((got & e[64:33]) !== (e[31:0] & e[64:33]) || ge !== e[32]) begin
         err_count++;
         $display("unexpected at %0t: got %h err %b want %h", $time, got, ge, e[31:0]);
      end
   endtask
   task automatic chk_pulse(input logic [3:0] want, input logic [3:0] got);
      n_checks++;
      if (got !== want) begin
         err_count++;
         $display("unexpected at %0t: pulses %h want %h", $time, got, want);
      end
   endtask
   // psel left high so a following transfer starts without a gap
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                      input logic [31:0] m, input logic e);
      int n;
      expq.push_back({m, e, dt});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      psel <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // pulses are unknown until the first reset edge
   always @(posedge mclk) begin
      if (pready === 1'b1) chk(expq.pop_front(), prdata, pslverr);
      if (!rst && cap !== 4'h0) chk_pulse(capq.size() ? capq.pop_front() : 4'h0, cap);
      if (!rst && mat !== 4'h0) chk_pulse(matq.size() ? matq.pop_front() : 4'h0, mat);
   end
   initial begin
      #100000;
      err_count++;
      print_verdict;
   end
   ////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, cnt, tick, drv, lvl, prev} = '0;
      rst = 1'b1;
      void'($urandom(32'h74FA37F3));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      wt(1);
      for (i = 0; i < 11; i++) apb(0, 8'(i * 4), 0, 32'hFFFFFFFF, i == 10);
      apb(1, 8'h28, 32'h5, 0, 1);
      $display("reset values done");
      for (i = 0; i < 9; i++) begin
         d = $urandom;
         apb(1, 8'(i * 4), d, 0, 0);
         apb(0, 8'(i * 4), d & ((i < 4) ? 32'hFF : (i < 8) ? 32'hFFFF : 32'h1FF), '1, 0);
      end
      for (i = 0; i < 10; i++) apb(1, 8'(i * 4), (i == 9) ? 32'hFF : 0, 0, 0);
      apb(0, 8'h24, 0, 32'hFF, 0);
      $display("access kinds done");
      for (j = 8; j < 16; j++) begin
         apb(1, 8'h08, 32'(j << 4), 0, 0);
         for (k = 1; k >= 0; k--) begin
            v = 16'($urandom);
            cnt[47:32] <= v;
            wt(2);
            drv[2] <= k[0];
            if (j[1] | (j[0] ^ k[0])) begin
               prev = v;
               capq.push_back(4'h4);
            end
            wt(8);
            apb(0, 8'h18, {16'h0, prev}, 32'hFFFF, 0);
         end
      end
      $display("pin capture done");
      for (j = 0; j < 8; j++) begin
         g = 16'($urandom);
         wt(1);
         cnt[47:32] <= g + 16'h1;
         apb(1, 8'h18, {16'h0, g}, 0, 0);
         apb(1, 8'h08, 32'(j << 4), 0, 0);
         en = j[1:0] != 2'h0;
         lvl = j[2];
         for (k = 0; k < 3; k++) begin
            wt(2);
            apb(0, 8'h24, 32'({en, 3'h0, lvl, 2'h0}), {25'h0, 1'b1, 3'h0, en, 2'h0}, 0);
            if (en) matq.push_back(4'h4);
            cnt[47:32] <= g;
            wt(3);
            cnt[47:32] <= g + 16'h1;
            lvl = (j[1:0] == 2'h3) ? !lvl : j[1];
         end
      end
      $display("compare output done");
      apb(1, 8'h00, 32'hC0, 0, 0);
      apb(1, 8'h04, 32'hC0, 0, 0);
      apb(1, 8'h0C, 32'h0C, 0, 0);
      {d3, b4, a0} = '0;
      for (k = 0; k < 3; k++) begin
         cfg = (k == 0) ? 9'h009 : (k == 1) ? 9'h000 : 9'h109;
         apb(1, 8'h20, {23'h0, cfg}, 0, 0);
         v = 16'($urandom);
         cnt <= {v, cnt[47:32], v, v};
         capq.push_back({cfg[5:3] != 3'h0, 1'b0, 1'b1, cfg[2:0] != 3'h0 && !cfg[8]});
         wt(2);
         tick <= 3'h7;
         wt(1);
         tick <= 3'h0;
         wt(3);
         if (cfg[2:0] != 3'h0 && !cfg[8]) d3 = v;
         if (cfg[5:3] != 3'h0) a0 = v;
         b4 = v;
         apb(0, 8'h10, {16'h0, d3}, 32'hFFFF, 0);
         apb(0, 8'h14, {16'h0, b4}, 32'hFFFF, 0);
         apb(0, 8'h1C, {16'h0, a0}, 32'hFFFF, 0);
      end
      wt(1);
      $display("cascade capture done");
      if (capq.size() != 0 || matq.size() != 0) begin
         err_count++;
         $display("unexpected at %0t: pulses missing", $time);
      end
      print_verdict;
   end
endmodule
